/* File: hdl/acm_pkg.sv */
// shared constants for the alarm condition monitor
package acm_pkg;
  // register byte addresses (low byte of each word)
  localparam logic [6:0] ADDR_THR1 = 7'h26;
  localparam logic [6:0] ADDR_THR2 = 7'h28;
  localparam logic [6:0] ADDR_SMP1 = 7'h2A;
  localparam logic [6:0] ADDR_SMP2 = 7'h2C;
  localparam logic [6:0] ADDR_CTRL = 7'h2E;
  // values after reset
  localparam logic [15:0] THR_RST = 16'h0000;
  localparam logic [7:0] SMP_RST = 8'h00;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] RD_RST = 16'h0000;
  // alarm control field positions
  localparam int CTRL_SRC2_LSB = 12;
  localparam int CTRL_SRC1_LSB = 8;
  localparam int CTRL_SLOPE2 = 7;
  localparam int CTRL_SLOPE1 = 6;
  localparam int CTRL_FILT = 4;
  localparam int CTRL_PIN_EN = 2;
  localparam int CTRL_PIN_POL = 1;
  localparam int CTRL_PIN_SEL = 0;
  // bits that store (unused bits 5 and 3 read as zero)
  localparam logic [15:0] CTRL_MASK = 16'hFFD7;
  // threshold fields
  localparam int THR_DIR = 15;
  localparam int DATA_W = 14;
  // source codes
  localparam int SRC_N = 11;
  localparam logic [3:0] SRC_OFF = 4'h0;
  localparam logic [3:0] SRC_LAST = 4'hB;
  localparam logic [3:0] SRC_SGN_LO = 4'h2;
  localparam logic [3:0] SRC_SGN_HI = 4'h7;
  // arithmetic widths
  localparam int SMP_W = 15;
  localparam int ACC_W = 24;
  // serial frame
  localparam logic [4:0] FRAME_LAST = 5'h0F;
  localparam logic [4:0] CNT_RST = 5'h00;
endpackage

/* File: hdl/acm_link.sv */
// serial frame shifter on the link clock
`timescale 1ns/1ps
`default_nettype none
module acm_link
  import acm_pkg::*;
(
  input wire logic sclk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic [15:0] rd_word_i,
  output logic miso_o,
  output logic [15:0] frm_word_o,
  output logic frm_tgl_o
);
  logic [4:0] cnt_r; // rising edges in this frame
  logic [14:0] sh_r; // incoming bits
  logic miso_r; // outgoing bit
  logic clr; // frame idle or reset
  logic [3:0] idx; // next outgoing bit index

  assign clr = cs_n_i | ~rst_n_i;
  assign idx = 4'hF - cnt_r[3:0];
  // first bit comes straight from the held word
  assign miso_o = (cnt_r == CNT_RST) ? rd_word_i[15] : miso_r;

  // bit counter, cleared while the frame is idle
  always_ff @(posedge sclk_i or posedge clr) begin
    if (clr) begin
      cnt_r <= CNT_RST;
      sh_r <= 15'h0000;
    end else begin
      cnt_r <= cnt_r + 5'h01;
      sh_r <= {sh_r[13:0], mosi_i};
    end
  end

  // finished word and toggle to the core clock
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frm_word_o <= 16'h0000;
      frm_tgl_o <= 1'b0;
    end else if (!cs_n_i && cnt_r == FRAME_LAST) begin
      frm_word_o <= {sh_r, mosi_i};
      frm_tgl_o <= ~frm_tgl_o;
    end
  end

  // read data leaves on the falling edge
  always_ff @(negedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      miso_r <= 1'b0;
    end else begin
      miso_r <= rd_word_i[idx];
    end
  end
endmodule
`default_nettype wire

/* File: hdl/acm_alarm.sv */
// one alarm: static or slope comparison against a threshold
`timescale 1ns/1ps
`default_nettype none
module acm_alarm
  import acm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic upd_i,
  input wire logic en_i,
  input wire logic sign_i,
  input wire logic slope_i,
  input wire logic [DATA_W-1:0] sample_i,
  input wire logic [15:0] thr_i,
  input wire logic [7:0] cnt_i,
  output logic flag_o
);
  logic signed [SMP_W-1:0] smp_s; // sample in common format
  logic signed [SMP_W-1:0] thr_s; // threshold in common format
  logic signed [SMP_W-1:0] prev_r; // last sample
  logic prev_ok_r; // last sample valid
  logic [7:0] cnt_r; // deltas in this window
  logic signed [ACC_W-1:0] acc_r; // delta sum so far
  logic signed [ACC_W-1:0] acc_nxt;
  logic signed [ACC_W-1:0] prod; // threshold times count
  logic signed [15:0] delta;
  logic [7:0] n_eff; // zero count acts as one
  logic dir; // greater than when set
  logic hit_static;
  logic hit_slope;
  logic last;

  // threshold value in low bits, bit 14 unused
  assign thr_s = sign_i ? {thr_i[DATA_W-1], thr_i[DATA_W-1:0]} : {1'b0, thr_i[DATA_W-1:0]};
  assign smp_s = sign_i ? {sample_i[DATA_W-1], sample_i} : {1'b0, sample_i};
  assign dir = thr_i[THR_DIR];
  assign n_eff = (cnt_i == SMP_RST) ? 8'h01 : cnt_i;
  assign delta = {smp_s[SMP_W-1], smp_s} - {prev_r[SMP_W-1], prev_r};
  assign acc_nxt = acc_r + {{(ACC_W-16){delta[15]}}, delta};
  // average above threshold means sum above threshold times count
  assign prod = thr_s * $signed({1'b0, n_eff});
  assign hit_static = dir ? (smp_s > thr_s) : (smp_s < thr_s);
  assign hit_slope = dir ? (acc_nxt > prod) : (acc_nxt < prod);
  assign last = (cnt_r + 8'h01) == n_eff;

  // evaluate once per update, hold between updates
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
      prev_r <= '0;
      prev_ok_r <= 1'b0;
      cnt_r <= SMP_RST;
      acc_r <= '0;
    end else if (ce_i) begin
      if (!en_i) begin // disabled source never alarms
        flag_o <= 1'b0;
        prev_ok_r <= 1'b0;
        cnt_r <= SMP_RST;
        acc_r <= '0;
      end else if (upd_i) begin
        prev_r <= smp_s;
        prev_ok_r <= 1'b1;
        if (!slope_i) begin // static level
          flag_o <= hit_static;
          cnt_r <= SMP_RST;
          acc_r <= '0;
        end else if (prev_ok_r && last) begin // window done
          flag_o <= hit_slope;
          cnt_r <= SMP_RST;
          acc_r <= '0;
        end else if (prev_ok_r) begin
          cnt_r <= cnt_r + 8'h01;
          acc_r <= acc_nxt;
        end
      end
    end
  end

  // static trip one cycle after the update
  chk_static_trip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && en_i && upd_i && !slope_i |=> flag_o == $past(hit_static))
    else $error("static comparison result not taken");
  // slope result only moves at the window end
  chk_slope_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && en_i && slope_i && !(upd_i && last && prev_ok_r) |=> $stable(flag_o))
    else $error("slope alarm moved inside a window");
  cov_slope_eval: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && en_i && slope_i && upd_i && prev_ok_r && last && hit_slope);
endmodule
`default_nettype wire

/* File: hdl/acm_top.sv */
// alarm condition monitor: serial registers, source select, pin drive
`timescale 1ns/1ps
`default_nettype none
module acm_top
  import acm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic upd_i,
  input wire logic [SRC_N-1:0][DATA_W-1:0] src_raw_i,
  input wire logic [SRC_N-1:0][DATA_W-1:0] src_filt_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic aux_io_line_a_o,
  output logic aux_io_line_a_oe_n_o,
  output logic aux_io_line_b_o,
  output logic aux_io_line_b_oe_n_o,
  output logic alarm1_o,
  output logic alarm2_o
);
  // registers
  logic [15:0] thr1_r; // alarm1_threshold
  logic [15:0] thr2_r; // alarm2_threshold
  logic [7:0] smp1_r; // alarm1_sample_count low byte
  logic [7:0] smp2_r; // alarm2_sample_count low byte
  logic [15:0] ctrl_r; // alarm_control
  logic [15:0] rd_word_r; // word served on the next frame
  logic [15:0] rd_nxt;
  logic [6:0] rd_addr_r; // address of the last read frame

  // link crossing
  logic [15:0] frm_word; // held stable across the toggle
  logic frm_tgl;
  logic tgl_s1_r; // first stage, read only by the second
  logic tgl_s2_r;
  logic tgl_s3_r;
  logic frm_ev; // one pulse per finished frame

  // frame decode
  logic fr_wr;
  logic [6:0] fr_addr;
  logic [7:0] fr_dat;
  logic fr_hi; // odd address writes the upper byte
  logic [6:0] fr_word_addr;
  logic wr_thr1;
  logic wr_thr2;
  logic wr_smp1;
  logic wr_smp2;
  logic wr_ctrl;

  // per alarm source handling
  logic [3:0] src_code [2];
  logic src_en [2];
  logic src_sgn [2];
  logic slope [2];
  logic [DATA_W-1:0] samp [2];
  logic [15:0] thr [2];
  logic [7:0] smpc [2];
  logic flag [2];

  // pin drive
  logic alarm_any;
  logic pin_lvl;

  // serial shifter on the link clock
  acm_link u_acm_link (
    .sclk_i(sclk_i),
    .rst_n_i(rst_n_i),
    .cs_n_i(cs_n_i),
    .mosi_i(mosi_i),
    .rd_word_i(rd_word_r),
    .miso_o(miso_o),
    .frm_word_o(frm_word),
    .frm_tgl_o(frm_tgl)
  );

  // toggle synchroniser, frozen with the clock enable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else if (ce_i) begin
      tgl_s1_r <= frm_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  // frame word is only read once its toggle has settled here
  assign frm_ev = tgl_s2_r ^ tgl_s3_r;
  assign fr_wr = frm_word[15];
  assign fr_addr = frm_word[14:8];
  assign fr_dat = frm_word[7:0];
  assign fr_hi = fr_addr[0];
  assign fr_word_addr = {fr_addr[6:1], 1'b0};
  assign wr_thr1 = frm_ev && fr_wr && fr_word_addr == ADDR_THR1;
  assign wr_thr2 = frm_ev && fr_wr && fr_word_addr == ADDR_THR2;
  assign wr_smp1 = frm_ev && fr_wr && fr_addr == ADDR_SMP1;
  assign wr_smp2 = frm_ev && fr_wr && fr_addr == ADDR_SMP2;
  assign wr_ctrl = frm_ev && fr_wr && fr_word_addr == ADDR_CTRL;

  // threshold registers, one byte per write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      thr1_r <= THR_RST;
      thr2_r <= THR_RST;
    end else if (ce_i) begin
      if (wr_thr1 && fr_hi) begin
        thr1_r[15:8] <= fr_dat;
      end else if (wr_thr1) begin
        thr1_r[7:0] <= fr_dat;
      end
      if (wr_thr2 && fr_hi) begin
        thr2_r[15:8] <= fr_dat;
      end else if (wr_thr2) begin
        thr2_r[7:0] <= fr_dat;
      end
    end
  end

  // sample counts keep only the low byte
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      smp1_r <= SMP_RST;
      smp2_r <= SMP_RST;
    end else if (ce_i) begin
      if (wr_smp1) begin
        smp1_r <= fr_dat;
      end
      if (wr_smp2) begin
        smp2_r <= fr_dat;
      end
    end
  end

  // control register, unused bits stay zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= CTRL_RST;
    end else if (ce_i && wr_ctrl && fr_hi) begin
      ctrl_r[15:8] <= fr_dat & CTRL_MASK[15:8];
    end else if (ce_i && wr_ctrl) begin
      ctrl_r[7:0] <= fr_dat & CTRL_MASK[7:0];
    end
  end

  // read word selection, unmapped reads zero
  always_comb begin
    rd_nxt = RD_RST;
    unique case (rd_addr_r)
      ADDR_THR1: rd_nxt = thr1_r;
      ADDR_THR2: rd_nxt = thr2_r;
      ADDR_SMP1: rd_nxt = {8'h00, smp1_r};
      ADDR_SMP2: rd_nxt = {8'h00, smp2_r};
      ADDR_CTRL: rd_nxt = ctrl_r;
      default: rd_nxt = RD_RST;
    endcase
  end

  // read frames latch an address; the word waits for the next frame
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_addr_r <= 7'h00;
      rd_word_r <= RD_RST;
    end else if (ce_i) begin
      if (frm_ev && !fr_wr) begin
        rd_addr_r <= fr_word_addr;
      end
      rd_word_r <= rd_nxt;
    end
  end

  // source fields and modes per alarm
  assign src_code[0] = ctrl_r[CTRL_SRC1_LSB +: 4];
  assign src_code[1] = ctrl_r[CTRL_SRC2_LSB +: 4];
  assign slope[0] = ctrl_r[CTRL_SLOPE1];
  assign slope[1] = ctrl_r[CTRL_SLOPE2];
  assign thr[0] = thr1_r;
  assign thr[1] = thr2_r;
  assign smpc[0] = smp1_r;
  assign smpc[1] = smp2_r;

  // two independent alarm units
  for (genvar g = 0; g < 2; g++) begin : g_alm
    logic [3:0] idx; // source array index
    assign src_en[g] = src_code[g] != SRC_OFF && src_code[g] <= SRC_LAST;
    assign idx = src_en[g] ? src_code[g] - 4'h1 : 4'h0;
    // rate and acceleration outputs are two's complement
    assign src_sgn[g] = src_code[g] >= SRC_SGN_LO && src_code[g] <= SRC_SGN_HI;
    // filtered or raw data feeds both alarms
    assign samp[g] = ctrl_r[CTRL_FILT] ? src_filt_i[idx] : src_raw_i[idx];
    acm_alarm u_acm_alarm (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .upd_i(upd_i),
      .en_i(src_en[g]),
      .sign_i(src_sgn[g]),
      .slope_i(slope[g]),
      .sample_i(samp[g]),
      .thr_i(thr[g]),
      .cnt_i(smpc[g]),
      .flag_o(flag[g])
    );
  end

  assign alarm1_o = flag[0];
  assign alarm2_o = flag[1];

  // pin drive: enable, polarity, line select
  assign alarm_any = flag[0] | flag[1];
  assign pin_lvl = ctrl_r[CTRL_PIN_POL] ? alarm_any : ~alarm_any;
  assign aux_io_line_a_o = pin_lvl;
  assign aux_io_line_b_o = pin_lvl;
  // enable low means driven
  assign aux_io_line_a_oe_n_o = ~(ctrl_r[CTRL_PIN_EN] & ~ctrl_r[CTRL_PIN_SEL]);
  assign aux_io_line_b_oe_n_o = ~(ctrl_r[CTRL_PIN_EN] & ctrl_r[CTRL_PIN_SEL]);

  // a disabled source never raises alarm 1
  chk_off_silent: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && ctrl_r[CTRL_SRC1_LSB +: 4] == SRC_OFF |=> !alarm1_o)
    else $error("alarm 1 active with source disabled");
  // no pin driven while output is off
  chk_pin_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ctrl_r[CTRL_PIN_EN] |-> aux_io_line_a_oe_n_o && aux_io_line_b_oe_n_o)
    else $error("alarm pin driven while disabled");
  // active low polarity on line a
  chk_pin_pol: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_r[CTRL_PIN_EN] && !ctrl_r[CTRL_PIN_POL]
      |-> aux_io_line_a_o == !(alarm1_o || alarm2_o))
    else $error("active low pin level wrong");
  // exactly the chosen line is driven
  chk_line_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_r[CTRL_PIN_EN] |-> aux_io_line_b_oe_n_o == !ctrl_r[CTRL_PIN_SEL]
      && aux_io_line_a_oe_n_o == ctrl_r[CTRL_PIN_SEL])
    else $error("wrong alarm line driven");
  // high control byte write lands next cycle
  chk_ctrl_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_ctrl && fr_hi |=> ctrl_r[15:8] == $past(fr_dat))
    else $error("control upper byte not written");
  // sample count upper byte reads zero
  chk_smp_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && rd_addr_r == ADDR_SMP1 |=> rd_word_r == {8'h00, $past(smp1_r)})
    else $error("sample count read wrong");
  // alarm 2 sees filtered data when asked
  chk_filt_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_r[CTRL_FILT] && src_code[1] == 4'h1 |-> samp[1] == src_filt_i[0])
    else $error("filtered source not selected");
  // a frame crossing becomes exactly one event
  chk_one_event: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    frm_ev && ce_i |=> !frm_ev)
    else $error("frame event repeated");

  // further checks on source disable, register writes and reads, holding, pin drive and data select

  // alarm 2 also stays quiet with its source disabled
  chk_off_silent2: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && src_code[1] == SRC_OFF |=> !alarm2_o)
    else $error("alarm 2 active with source disabled");

  // codes above the last source act as disabled on alarm 1
  chk_codes_high1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && src_code[0] > SRC_LAST |=> !alarm1_o)
    else $error("alarm 1 active with unknown source code");

  // codes above the last source act as disabled on alarm 2
  chk_codes_high2: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && src_code[1] > SRC_LAST |=> !alarm2_o)
    else $error("alarm 2 active with unknown source code");

  // low control byte lands with unused bits cleared
  chk_ctrl_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_ctrl && !fr_hi |=> ctrl_r[7:0] == ($past(fr_dat) & CTRL_MASK[7:0]))
    else $error("control lower byte not written");

  // threshold 1 upper byte carries the direction bit
  chk_thr_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_thr1 && fr_hi |=> thr1_r[15:8] == $past(fr_dat))
    else $error("threshold upper byte not written");

  // threshold 2 lower byte carries value bits
  chk_thr_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_thr2 && !fr_hi |=> thr2_r[7:0] == $past(fr_dat))
    else $error("threshold lower byte not written");

  // upper sample count byte ignores writes
  chk_smp_upper: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && frm_ev && fr_wr && fr_addr == ADDR_SMP1 + 7'h01 |=> $stable(smp1_r))
    else $error("sample count upper byte stored");

  // read frames latch the word address
  chk_rd_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && frm_ev && !fr_wr |=> rd_addr_r == $past(fr_word_addr))
    else $error("read address not latched");

  // control register is served back as stored
  chk_rd_ctrl: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && rd_addr_r == ADDR_CTRL |=> rd_word_r == $past(ctrl_r))
    else $error("control read word wrong");

  // clock enable low freezes settings and alarms
  chk_ce_freeze: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ce_i |=> $stable(ctrl_r) && $stable(alarm1_o) && $stable(alarm2_o))
    else $error("state moved with clock enable low");

  // alarm 1 holds between updates
  chk_hold1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !upd_i && src_en[0] |=> $stable(alarm1_o))
    else $error("alarm 1 moved without an update");

  // alarm 2 holds between updates
  chk_hold2: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !upd_i && src_en[1] |=> $stable(alarm2_o))
    else $error("alarm 2 moved without an update");

  // active high level on line b
  chk_pin_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctrl_r[CTRL_PIN_EN] && ctrl_r[CTRL_PIN_POL] |-> aux_io_line_b_o == (alarm1_o || alarm2_o))
    else $error("active high pin level wrong");

  // alarm 1 sees raw data unless filtering is asked
  chk_raw_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ctrl_r[CTRL_FILT] && src_code[0] == 4'h1 |-> samp[0] == src_raw_i[0])
    else $error("raw source not selected");

  cov_alarm1: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(alarm1_o));
  cov_both: cover property (@(posedge clk_i) disable iff (!rst_n_i) alarm1_o && alarm2_o);
  cov_pin_b: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    !aux_io_line_b_oe_n_o && alarm2_o);
endmodule
`default_nettype wire

/* File: dv/acm_spi_host.sv */
// host model that drives the serial register link of the monitor
`timescale 1ns/1ps
`default_nettype none
module acm_spi_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // link idles with clock high and select high
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // one 16-bit frame, msb first, clock idles high, 32 ns per bit
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    // odd offset keeps the link out of step with the core clock
    #5;
    cs_n_o = 1'b0;
    mosi_o = tx[15];
    for (int i = 15; i >= 0; i--) begin
      #16 sclk_o = 1'b0;
      mosi_o = tx[i];
      #16 sclk_o = 1'b1;
      rx[i] = miso_i;
    end
    #16 cs_n_o = 1'b1;
    // released data line shows the opposite of its last bit
    mosi_o = ~tx[0];
    // gap well above the four core cycles needed between frames
    #64;
  endtask
endmodule
`default_nettype wire

/* File: dv/acm_tb_top.sv */
// self-checking bench for the alarm condition monitor
`timescale 1ns/1ps
`default_nettype none
module acm_tb_top;
  import acm_pkg::*;
  logic clk_i = 1'b0; // core clock
  logic rst_n_i = 1'b0; // active low reset
  logic ce_i = 1'b1; // clock enable
  logic upd_i = 1'b0; // update strobe
  logic [SRC_N-1:0][DATA_W-1:0] raw = '0; // unfiltered sources
  logic [SRC_N-1:0][DATA_W-1:0] filt = '0; // filtered sources
  wire sclk, cs_n, mosi, miso; // link wires
  wire pa, pa_oe_n, pb, pb_oe_n, al1, al2; // pins and status
  int errors = 0; // mismatch count
  int checks = 0; // comparison count
  logic [15:0] d; // read data
  // 250 MHz core clock
  always #2 clk_i = ~clk_i;
  acm_top u_acm_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .upd_i(upd_i),
    .src_raw_i(raw), .src_filt_i(filt), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso), .aux_io_line_a_o(pa), .aux_io_line_a_oe_n_o(pa_oe_n),
    .aux_io_line_b_o(pb), .aux_io_line_b_oe_n_o(pb_oe_n), .alarm1_o(al1), .alarm2_o(al2));
  acm_spi_host u_acm_spi_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
  // compare one value against its expectation
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // write one byte through the link
  task automatic wr(input logic [6:0] a, input logic [7:0] b);
    logic [15:0] x;
    u_acm_spi_host.xfer({1'b1, a, b}, x);
    @(negedge clk_i);
  endtask
  // read one word: address frame, then data frame
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    logic [15:0] x;
    u_acm_spi_host.xfer({1'b0, a, 8'h00}, x);
    u_acm_spi_host.xfer(16'h0000, v);
    @(negedge clk_i);
  endtask
  // one update pulse, then let the result settle
  task automatic upd();
    @(negedge clk_i) upd_i = 1'b1;
    @(negedge clk_i) upd_i = 1'b0;
    @(negedge clk_i);
  endtask
  // print verdict and stop
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // values after reset, pins idle, unmapped read
  task automatic t_reset();
    chk(al1, 1'b0);
    chk(al2, 1'b0);
    chk({pa_oe_n, pb_oe_n, pa, pb}, 4'hF);
    rd(ADDR_THR1, d);
    chk(d, 16'h0000);
    rd(ADDR_THR2, d);
    chk(d, 16'h0000);
    rd(ADDR_SMP1, d);
    chk(d, 16'h0000);
    rd(ADDR_SMP2, d);
    chk(d, 16'h0000);
    rd(ADDR_CTRL, d);
    chk(d, 16'h0000);
    rd(7'h30, d);
    chk(d, 16'h0000);
    $display("test reset done");
  endtask
  // register storage, masks and ignored writes
  task automatic t_regs();
    wr(ADDR_THR1, 8'hFF);
    wr(ADDR_THR1 + 7'h01, 8'hFF);
    rd(ADDR_THR1, d);
    chk(d, 16'hFFFF);
    wr(ADDR_SMP1, 8'hA5);
    wr(ADDR_SMP1 + 7'h01, 8'hFF);
    rd(ADDR_SMP1, d);
    chk(d, 16'h00A5);
    wr(ADDR_CTRL, 8'hFF);
    wr(ADDR_CTRL + 7'h01, 8'hFF);
    rd(ADDR_CTRL, d);
    chk(d, 16'hFFD7);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL + 7'h01, 8'h00);
    wr(7'h30, 8'h5A);
    rd(7'h30, d);
    chk(d, 16'h0000);
    $display("test regs done");
  endtask
  // every source code, both directions, disable and clock enable
  task automatic t_static();
    wr(ADDR_THR1, 8'h64);
    wr(ADDR_THR1 + 7'h01, 8'hC0);
    wr(ADDR_THR2, 8'h64);
    wr(ADDR_THR2 + 7'h01, 8'h00);
    for (int c = 1; c <= 11; c++) begin
      raw = '0;
      wr(ADDR_CTRL + 7'h01, {c[3:0], c[3:0]});
      raw[c-1] = 14'd200;
      upd();
      chk(al1, 1'b1);
      chk(al2, 1'b0);
      raw[c-1] = 14'd50;
      upd();
      chk(al1, 1'b0);
      chk(al2, 1'b1);
    end
    wr(ADDR_CTRL + 7'h01, 8'h00);
    raw = {SRC_N{14'd200}};
    upd();
    chk({al1, al2}, 2'b00);
    wr(ADDR_CTRL + 7'h01, 8'h11);
    upd();
    chk(al1, 1'b1);
    ce_i = 1'b0;
    raw[0] = 14'd50;
    upd();
    chk(al1, 1'b1);
    ce_i = 1'b1;
    $display("test static done");
  endtask
  // filtered against unfiltered data
  task automatic t_filter();
    raw[0] = 14'd200;
    filt[0] = 14'd50;
    wr(ADDR_CTRL, 8'h10);
    upd();
    chk({al1, al2}, 2'b01);
    wr(ADDR_CTRL, 8'h00);
    upd();
    chk({al1, al2}, 2'b10);
    $display("test filter done");
  endtask
  // pin enable, polarity and line select for both alarm states
  task automatic t_pins();
    logic [2:0] m;
    wr(ADDR_CTRL + 7'h01, 8'h01);
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      wr(ADDR_CTRL, {5'h00, m});
      for (int a = 0; a < 2; a++) begin
        raw[0] = (a == 1) ? 14'd200 : 14'd50;
        upd();
        chk(pa_oe_n, !(m[2] && !m[0]));
        chk(pb_oe_n, !(m[2] && m[0]));
        if (m[2] && m[0]) begin
          chk(pb, m[1] == (a == 1));
        end else if (m[2]) begin
          chk(pa, m[1] == (a == 1));
        end
      end
    end
    $display("test pins done");
  endtask
  // averaged rate of change on both alarms, opposite directions
  task automatic t_slope();
    logic [13:0] s[9] = '{100, 120, 140, 160, 180, 185, 190, 195, 200};
    wr(ADDR_CTRL + 7'h01, 8'h00);
    wr(ADDR_SMP1, 8'h04);
    wr(ADDR_SMP2, 8'h04);
    wr(ADDR_THR1, 8'h0A);
    wr(ADDR_THR1 + 7'h01, 8'h80);
    wr(ADDR_THR2, 8'h0A);
    wr(ADDR_CTRL, 8'hC0);
    wr(ADDR_CTRL + 7'h01, 8'h11);
    for (int k = 0; k < 9; k++) begin
      raw[0] = s[k];
      upd();
      if (k == 4 || k == 6) begin
        chk({al1, al2}, 2'b10);
      end
    end
    chk({al1, al2}, 2'b01);
    $display("test slope done");
  endtask
  // watchdog well beyond the expected run
  initial begin
    #300000;
    errors++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    t_reset();
    t_regs();
    t_static();
    t_filter();
    t_pins();
    t_slope();
    final_report();
  end
endmodule
`default_nettype wire
